// File: hw/ela_cfg.svh
// Constants for the embedded capture analyzer: command layout, reset values and timing.
`ifndef ELA_CFG_SVH
`define ELA_CFG_SVH

`define ELA_TRIG_W      8
`define ELA_DATA_W      16
`define ELA_ARG_W       16
`define ELA_CMD_W       26
`define ELA_OP_LSB      22
`define ELA_UNIT_LSB    16
`define ELA_PAD_W       9
`define ELA_MAX_TRIG    16
`define ELA_MAX_MU      4
`define ELA_MAX_DATA_W  256
`define ELA_DEPTH_NEW   16384
`define ELA_DEPTH_OLD   4096
`define ELA_CNT_RST     8'h00
`define ELA_CNT_LAST    8'hFE
`define ELA_MASK_RST    8'h00
`define ELA_VAL_RST     8'h00
`define ELA_PHASE_QTR   8'h40
`define ELA_SIN_SAT     8'h7F
`define ELA_PIPE_LAT    2
`define ELA_DESIGN_CLK_NS 25
`define ELA_CORE_CLK_NS 10

`endif

// File: hw/ela_jtag_hub.sv
// JTAG control hub: user data register on the test clock, toggle handshake to the core.
`timescale 1ns/100ps
`default_nettype none
`include "ela_cfg.svh"
module ela_jtag_hub (
  input  wire logic tck,
  input  wire logic resetn,
  input  wire logic tdi,
  input  wire logic jtag_capture,
  input  wire logic jtag_shift,
  input  wire logic jtag_update,
  output logic      tdo,
  ela_link_if.hub   link
);
  logic                  trs1;
  logic                  trs2;
  logic [`ELA_CMD_W-1:0] sr;
  logic                  ack_s1;
  logic                  ack_s2;
  logic                  ack_s3;
  logic [`ELA_ARG_W-1:0] rsp_hold;
  wire                   busy = link.req ^ ack_s3;
  wire                   rsp_arrive = ack_s2 ^ ack_s3;

  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      trs1 <= 1'b0;
      trs2 <= 1'b0;
    end else begin
      trs1 <= 1'b1;
      trs2 <= trs1;
    end
  end

  // The command word is held still until the core answers, so it crosses as a bundle.
  always_ff @(posedge tck or negedge trs2) begin
    if (!trs2) begin
      sr       <= '0;
      link.cmd <= '0;
      link.req <= 1'b0;
      ack_s1   <= 1'b0;
      ack_s2   <= 1'b0;
      ack_s3   <= 1'b0;
      rsp_hold <= '0;
    end else begin
      if (jtag_capture) begin
        sr <= {busy, `ELA_PAD_W'(0), rsp_hold};
      end else if (jtag_shift) begin
        sr <= {tdi, sr[`ELA_CMD_W-1:1]};
      end
      if (jtag_update && !busy) begin
        link.cmd <= sr;
        link.req <= ~link.req;
      end
      ack_s1 <= link.ack;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      if (rsp_arrive) begin
        rsp_hold <= link.rsp;
      end
    end
  end

  assign tdo = sr[0];

endmodule // ela_jtag_hub
`default_nettype wire

// File: hw/ela_link_if.sv
// Command and response link between the JTAG hub and the capture core.
`timescale 1ns/100ps
`default_nettype none
`include "ela_cfg.svh"
interface ela_link_if;
  logic [`ELA_CMD_W-1:0] cmd;
  logic                  req;
  logic [`ELA_ARG_W-1:0] rsp;
  logic                  ack;
  modport hub  (output cmd, output req, input rsp, input ack);
  modport core (input cmd, input req, output rsp, output ack);
endinterface
`default_nettype wire

// File: hw/ela_pkg.sv
// Types shared by the embedded capture analyzer modules.
package ela_pkg;

  typedef enum logic [1:0] {
    ELA_IDLE  = 2'b00,
    ELA_ARMED = 2'b01,
    ELA_CAPT  = 2'b10,
    ELA_DONE  = 2'b11
  } ela_state_t;

  typedef enum logic [3:0] {
    ELA_OP_NOP     = 4'b0000,
    ELA_OP_WR_VAL  = 4'b0001,
    ELA_OP_WR_HI   = 4'b0010,
    ELA_OP_WR_MASK = 4'b0011,
    ELA_OP_WR_CMP  = 4'b0100,
    ELA_OP_ARM     = 4'b0101,
    ELA_OP_STOP    = 4'b0110,
    ELA_OP_RD_STAT = 4'b0111,
    ELA_OP_RD_DATA = 4'b1000
  } ela_op_t;

  typedef enum logic [3:0] {
    ELA_CMP_EQ   = 4'b0000,
    ELA_CMP_NE   = 4'b0001,
    ELA_CMP_GT   = 4'b0010,
    ELA_CMP_LT   = 4'b0011,
    ELA_CMP_LE   = 4'b0100,
    ELA_CMP_GE   = 4'b0101,
    ELA_CMP_IN   = 4'b0110,
    ELA_CMP_OUT  = 4'b0111,
    ELA_CMP_RISE = 4'b1000,
    ELA_CMP_FALL = 4'b1001
  } ela_cmp_t;

  typedef enum logic [1:0] {
    ELA_MT_BASIC    = 2'b00,
    ELA_MT_EXTENDED = 2'b01,
    ELA_MT_RANGE    = 2'b10
  } ela_mtype_t;

endpackage

// File: hw/ela_top.sv
// Embedded capture analyzer with demo stimulus, match units, capture memory and JTAG hub.
`timescale 1ns/100ps
`default_nettype none
`include "ela_cfg.svh"
module ela_top #(
  parameter int                  NUM_TRIG   = 1,
  parameter int                  MU         = 1,
  parameter ela_pkg::ela_mtype_t MTYPE      = ela_pkg::ELA_MT_BASIC,
  parameter bit                  EDGES      = 1'b1,
  parameter int                  DEPTH      = 512,
  parameter bit                  NEW_FAMILY = 1'b1
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic tck,
  input  wire logic tdi,
  input  wire logic jtag_capture,
  input  wire logic jtag_shift,
  input  wire logic jtag_update,
  output logic      tdo,
  output logic      led
);
  localparam int TW = `ELA_TRIG_W;
  localparam int DW = `ELA_DATA_W;
  localparam int NU = NUM_TRIG * MU;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int MAXD = NEW_FAMILY ? `ELA_DEPTH_NEW : `ELA_DEPTH_OLD;
  localparam int DEMO_PERIOD_NS = `ELA_DESIGN_CLK_NS;
  localparam int CORE_PERIOD_NS = `ELA_CORE_CLK_NS;

  if (NUM_TRIG < 1 || NUM_TRIG > `ELA_MAX_TRIG) begin : g_bad_trig
    $error("Trigger port count must be 1 to 16.");
  end
  if (MU < 1 || MU > `ELA_MAX_MU) begin : g_bad_mu
    $error("Match units per port must be 1 to 4.");
  end
  if (DW > `ELA_MAX_DATA_W) begin : g_bad_dw
    $error("Sample width exceeds 256 bits.");
  end
  if (DEPTH < 1 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > MAXD) begin : g_bad_depth
    $error("Capture depth must be a power of two within the family limit.");
  end
  if (DEMO_PERIOD_NS < CORE_PERIOD_NS) begin : g_bad_clk
    $error("Demo clock period below the supported core period.");
  end

  // Reset release synchroniser for the core domain.
  logic rs1;
  logic rs2;
  wire  rst_n = rs2;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rs1 <= 1'b0;
      rs2 <= 1'b0;
    end else begin
      rs1 <= 1'b1;
      rs2 <= rs1;
    end
  end

  // Demo stimulus: wrapping counter and two-stage parabolic sine/cosine table.
  logic [7:0] cnt;
  logic [7:0] phase_q;
  logic [7:0] sin_q;
  logic [7:0] cos_q;

  function automatic logic [7:0] ela_sin(input logic [7:0] p);
    logic [14:0] y;
    logic [7:0]  m;
    y = 15'(p[6:0]) * (15'h0080 - 15'(p[6:0]));
    m = (y[14:5] > 10'(`ELA_SIN_SAT)) ? `ELA_SIN_SAT : y[12:5];
    return p[7] ? 8'(-m) : m;
  endfunction

  wire [7:0] next_cnt = (cnt == `ELA_CNT_LAST) ? `ELA_CNT_RST : cnt + 8'h01;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= `ELA_CNT_RST;
      phase_q <= `ELA_CNT_RST;
      sin_q   <= 8'h00;
      cos_q   <= 8'h00;
      led     <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      led     <= cnt[7];
      phase_q <= cnt;
      sin_q   <= ela_sin(phase_q);
      cos_q   <= ela_sin(phase_q + `ELA_PHASE_QTR);
    end
  end

  wire [NUM_TRIG*TW-1:0] trig_bus = {NUM_TRIG{cnt}};
  wire [DW-1:0]          data_bus = {sin_q, cos_q};
  logic [NUM_TRIG*TW-1:0] trig_prev;

  // Command link from the hub; only req crosses, the word is stable while it is pending.
  ela_link_if link ();

  ela_jtag_hub u_hub (
    .tck          (tck),
    .resetn       (resetn),
    .tdi          (tdi),
    .jtag_capture (jtag_capture),
    .jtag_shift   (jtag_shift),
    .jtag_update  (jtag_update),
    .tdo          (tdo),
    .link         (link.hub)
  );

  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic rsp_pend;
  ela_pkg::ela_op_t op_q;

  wire                   new_cmd  = req_s2 ^ req_s3;
  wire ela_pkg::ela_op_t cmd_op   = ela_pkg::ela_op_t'(link.cmd[`ELA_CMD_W-1:`ELA_OP_LSB]);
  wire [5:0]             cmd_unit = link.cmd[`ELA_OP_LSB-1:`ELA_UNIT_LSB];
  wire [`ELA_ARG_W-1:0]  cmd_arg  = link.cmd[`ELA_ARG_W-1:0];
  wire                   cmd_arm  = new_cmd && cmd_op == ela_pkg::ELA_OP_ARM;
  wire                   cmd_stop = new_cmd && cmd_op == ela_pkg::ELA_OP_STOP;

  // Match unit configuration, written by the host at run time.
  logic [TW-1:0]      u_val  [NU];
  logic [TW-1:0]      u_hi   [NU];
  logic [TW-1:0]      u_mask [NU];
  ela_pkg::ela_cmp_t  u_cmp  [NU];
  logic [NU-1:0]      u_en;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NU; i++) begin
        u_val[i]  <= `ELA_VAL_RST;
        u_hi[i]   <= `ELA_VAL_RST;
        u_mask[i] <= `ELA_MASK_RST;
        u_cmp[i]  <= ela_pkg::ELA_CMP_EQ;
        u_en[i]   <= (i == 0);
      end
    end else if (new_cmd && 32'(cmd_unit) < NU) begin
      for (int i = 0; i < NU; i++) begin
        if (32'(cmd_unit) == i) begin
          case (cmd_op)
            ela_pkg::ELA_OP_WR_VAL: begin
              u_val[i] <= cmd_arg[TW-1:0];
            end
            ela_pkg::ELA_OP_WR_HI: begin
              u_hi[i] <= cmd_arg[TW-1:0];
            end
            ela_pkg::ELA_OP_WR_MASK: begin
              u_mask[i] <= cmd_arg[TW-1:0];
            end
            ela_pkg::ELA_OP_WR_CMP: begin
              u_cmp[i] <= ela_pkg::ela_cmp_t'(cmd_arg[3:0]);
              u_en[i]  <= cmd_arg[4];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // Comparisons the configured match type does not offer never match.
  function automatic logic ela_ok(input ela_pkg::ela_cmp_t c);
    case (c)
      ela_pkg::ELA_CMP_EQ, ela_pkg::ELA_CMP_NE: return 1'b1;
      ela_pkg::ELA_CMP_GT, ela_pkg::ELA_CMP_LT,
      ela_pkg::ELA_CMP_LE, ela_pkg::ELA_CMP_GE: return MTYPE != ela_pkg::ELA_MT_BASIC;
      ela_pkg::ELA_CMP_IN, ela_pkg::ELA_CMP_OUT: return MTYPE == ela_pkg::ELA_MT_RANGE;
      ela_pkg::ELA_CMP_RISE, ela_pkg::ELA_CMP_FALL: return EDGES;
      default: return 1'b0;
    endcase
  endfunction

  // Mask bits at zero are don't-care for values and are ignored for edges.
  function automatic logic ela_match(input logic [TW-1:0] cur, input logic [TW-1:0] prv,
                                     input logic [TW-1:0] val, input logic [TW-1:0] hi,
                                     input logic [TW-1:0] msk, input ela_pkg::ela_cmp_t c);
    logic [TW-1:0] a;
    logic [TW-1:0] v;
    logic [TW-1:0] h;
    a = cur & msk;
    v = val & msk;
    h = hi & msk;
    case (c)
      ela_pkg::ela_cmp_t'(ela_pkg::ELA_CMP_EQ): return a == v;
      ela_pkg::ELA_CMP_NE:   return a != v;
      ela_pkg::ELA_CMP_GT:   return a > v;
      ela_pkg::ELA_CMP_LT:   return a < v;
      ela_pkg::ELA_CMP_LE:   return a <= v;
      ela_pkg::ELA_CMP_GE:   return a >= v;
      ela_pkg::ELA_CMP_IN:   return a >= v && a <= h;
      ela_pkg::ELA_CMP_OUT:  return a < v || a > h;
      ela_pkg::ELA_CMP_RISE: return |(msk & cur & ~prv);
      ela_pkg::ELA_CMP_FALL: return |(msk & ~cur & prv);
      default:               return 1'b0;
    endcase
  endfunction

  logic [NU-1:0] hit;

  for (genvar u = 0; u < NU; u++) begin : g_unit
    localparam int P = u / MU;
    assign hit[u] = ela_ok(u_cmp[u]) && ela_match(trig_bus[P*TW +: TW], trig_prev[P*TW +: TW],
                                                  u_val[u], u_hi[u], u_mask[u], u_cmp[u]);
  end

  wire trig_hit = &(hit | ~u_en);

  // Capture sequencer and buffer.
  ela_pkg::ela_state_t state;
  ela_pkg::ela_state_t next_state;
  logic [AW-1:0]       wr_addr;
  logic [DW-1:0]       mem [DEPTH];
  logic [DW-1:0]       rd_q;

  wire mem_we = state == ela_pkg::ELA_CAPT || (state == ela_pkg::ELA_ARMED && trig_hit);
  wire last   = wr_addr == AW'(DEPTH - 1);

  always_comb begin
    next_state = state;
    case (state)
      ela_pkg::ELA_IDLE: begin
        if (cmd_arm) next_state = ela_pkg::ELA_ARMED;
      end
      ela_pkg::ELA_ARMED: begin
        if (cmd_stop) next_state = ela_pkg::ELA_IDLE;
        else if (trig_hit) next_state = last ? ela_pkg::ELA_DONE : ela_pkg::ELA_CAPT;
      end
      ela_pkg::ELA_CAPT: begin
        if (cmd_stop) next_state = ela_pkg::ELA_IDLE;
        else if (last) next_state = ela_pkg::ELA_DONE;
      end
      ela_pkg::ELA_DONE: begin
        if (cmd_arm) next_state = ela_pkg::ELA_ARMED;
        else if (cmd_stop) next_state = ela_pkg::ELA_IDLE;
      end
      default: next_state = ela_pkg::ELA_IDLE;
    endcase
    if (cmd_arm) next_state = ela_pkg::ELA_ARMED;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ela_pkg::ELA_IDLE;
      wr_addr   <= '0;
      trig_prev <= '0;
    end else begin
      state     <= next_state;
      trig_prev <= trig_bus;
      if (cmd_arm) wr_addr <= '0;
      else if (mem_we && !last) wr_addr <= wr_addr + AW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (mem_we && !cmd_stop) mem[wr_addr] <= data_bus;
    rd_q <= mem[cmd_arg[AW-1:0]];
  end

  // Every command is answered two cycles after it is seen, with status or a sample.
  wire [`ELA_ARG_W-1:0] status = {state, (`ELA_ARG_W-2)'(wr_addr)};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1   <= 1'b0;
      req_s2   <= 1'b0;
      req_s3   <= 1'b0;
      rsp_pend <= 1'b0;
      op_q     <= ela_pkg::ELA_OP_NOP;
      link.rsp <= '0;
      link.ack <= 1'b0;
    end else begin
      req_s1   <= link.req;
      req_s2   <= req_s1;
      req_s3   <= req_s2;
      rsp_pend <= new_cmd;
      op_q     <= cmd_op;
      if (rsp_pend) begin
        link.rsp <= (op_q == ela_pkg::ELA_OP_RD_DATA) ? `ELA_ARG_W'(rd_q) : status;
        link.ack <= ~link.ack;
      end
    end
  end

  // Checks.
  cnt_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cnt == `ELA_CNT_LAST |=> cnt == `ELA_CNT_RST)
    else $error("Counter did not wrap after 254.");

  led_msb_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 led == $past(cnt[7]))
    else $error("LED does not follow the counter top bit.");

  sine_lag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##2 sin_q == ela_sin($past(cnt, 2)))
    else $error("Sine output does not lag the counter by two cycles.");

  trig_all_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == ela_pkg::ELA_ARMED && (hit & u_en) != u_en && !cmd_arm && !cmd_stop
      |-> !mem_we ##1 state == ela_pkg::ELA_ARMED)
    else $error("Capture started while an enabled unit missed.");

  eq_unit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    u_cmp[0] == ela_pkg::ELA_CMP_EQ |->
      hit[0] == ((trig_bus[TW-1:0] & u_mask[0]) == (u_val[0] & u_mask[0])))
    else $error("Equality match unit gives the wrong answer.");

  sequence s_armed_hit;
    state == ela_pkg::ELA_ARMED && trig_hit && !cmd_stop && !cmd_arm && !last;
  endsequence

  arm_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_armed_hit |=> state == ela_pkg::ELA_CAPT && wr_addr == AW'(1))
    else $error("Capture did not start on the trigger.");

  full_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mem_we && last && !cmd_stop && !cmd_arm |=> state == ela_pkg::ELA_DONE && !mem_we)
    else $error("Capture did not stop when the buffer filled.");

  idle_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == ela_pkg::ELA_IDLE || state == ela_pkg::ELA_DONE |-> !mem_we)
    else $error("Buffer written outside a capture.");

  link_ack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    new_cmd |-> ##2 link.ack != $past(link.ack))
    else $error("Command not answered two cycles after it was seen.");

endmodule // ela_top
`default_nettype wire

// File: tb/ela_host_model.sv
// Host analyzer model: shifts commands into the JTAG data register and polls answers.
`timescale 1ns/100ps
`default_nettype none
module ela_host_model (
  output logic      tck,
  output logic      tdi,
  output logic      jtag_capture,
  output logic      jtag_shift,
  output logic      jtag_update,
  input  wire logic tdo
);
  // The test clock runs only while a task ticks it (frames, update, idle) and rests high between ticks.
  initial begin
    tck = 1'b1;
    tdi = 1'b0;
    jtag_capture = 1'b0;
    jtag_shift = 1'b0;
    jtag_update = 1'b0;
  end

  task automatic tick();
    #23 tck = 1'b0;
    #24 tck = 1'b1;
    #1;
  endtask

  task automatic idle(input int n);
    repeat (n) tick();
  endtask

  // Captures the answer word and shifts it out while the next word goes in.
  task automatic frame(input logic [25:0] wr, output logic [25:0] rd);
    jtag_capture = 1'b1;
    tick();
    jtag_capture = 1'b0;
    jtag_shift = 1'b1;
    for (int i = 0; i < 26; i++) begin
      tdi = wr[i];
      rd[i] = tdo;
      tick();
    end
    jtag_shift = 1'b0;
    tdi = ~tdi;
  endtask

  // Issues one command, then polls until the busy bit of the answer clears.
  task automatic cmd(input ela_pkg::ela_op_t op, input logic [5:0] unit,
                     input logic [15:0] arg, output logic [15:0] rsp, output logic ok);
    logic [25:0] rd;
    frame({op, unit, arg}, rd);
    jtag_update = 1'b1;
    tick();
    jtag_update = 1'b0;
    ok = 1'b0;
    for (int n = 0; n < 12 && !ok; n++) begin
      frame(26'h0000000, rd);
      ok = (rd[25] === 1'b0);
    end
    rsp = rd[15:0];
  endtask
endmodule // ela_host_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the embedded capture analyzer driven by the host model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [3:0] cmp;
    logic [7:0] val;
    logic [7:0] hi;
    logic [7:0] msk;
    logic [3:0] cmp1;
    logic [7:0] val1;
    logic       en1;
    logic [7:0] hit;
  } ela_case_t;

  logic core_clk, resetn, tck, tdi, jtag_capture, jtag_shift, jtag_update, tdo, led;
  int   n_mismatch;
  int   check_count;

  ela_top #(.MU(2), .MTYPE(ela_pkg::ELA_MT_RANGE), .DEPTH(512)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .tck(tck), .tdi(tdi),
    .jtag_capture(jtag_capture), .jtag_shift(jtag_shift),
    .jtag_update(jtag_update), .tdo(tdo), .led(led));

  ela_host_model host_u (.tck(tck), .tdi(tdi), .jtag_capture(jtag_capture),
    .jtag_shift(jtag_shift), .jtag_update(jtag_update), .tdo(tdo));

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] sine(input logic [7:0] ph);
    int x, m;
    x = ph[6:0];
    m = (x * (128 - x)) >> 5;
    if (m > 127)
      m = 127;
    return ph[7] ? 8'(-m) : 8'(m);
  endfunction

  // Sample data seen when the counter holds p: table of the value two cycles earlier.
  function automatic logic [15:0] expect_at(input int p);
    logic [7:0] q;
    q = 8'((p + 253) % 255);
    return {sine(q), sine(q + 8'h40)};
  endfunction

  task automatic run(input ela_pkg::ela_op_t op, input logic [5:0] u,
                     input logic [15:0] a, output logic [15:0] r);
    logic ok;
    host_u.cmd(op, u, a, r, ok);
    check({15'h0000, ok}, 16'h0001, "answer ready");
  endtask

  task automatic wr(input ela_pkg::ela_op_t op, input logic [5:0] u, input logic [15:0] a);
    logic [15:0] r;
    run(op, u, a, r);
  endtask

  task automatic wait_state(input logic [1:0] want, input int tries);
    logic [15:0] r;
    for (int n = 0; n < tries; n++) begin
      run(ela_pkg::ELA_OP_RD_STAT, 6'h00, 16'h0000, r);
      if (r[15:14] === want)
        break;
    end
    check({14'h0000, r[15:14]}, {14'h0000, want}, "capture state");
  endtask

  task automatic hold_len(input logic lvl, output int n);
    n = 0;
    while (led === lvl && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  task automatic t_led();
    int hi, lo, skip;
    hold_len(1'b1, skip);
    hold_len(1'b0, skip);
    hold_len(1'b1, hi);
    hold_len(1'b0, lo);
    check(16'(hi), 16'h007F, "led high span");
    check(16'(lo), 16'h0080, "led low span");
    $display("test led done");
  endtask

  task automatic t_default();
    logic [15:0] s0, s1, s9, st;
    int p0;
    wr(ela_pkg::ELA_OP_ARM, 6'h00, 16'h0000);
    wait_state(2'h3, 20);
    run(ela_pkg::ELA_OP_RD_STAT, 6'h00, 16'h0000, st);
    check({2'b00, st[13:0]}, 16'h01FF, "write pointer at full");
    run(ela_pkg::ELA_OP_RD_DATA, 6'h00, 16'h0000, s0);
    run(ela_pkg::ELA_OP_RD_DATA, 6'h00, 16'h0001, s1);
    run(ela_pkg::ELA_OP_RD_DATA, 6'h00, 16'h01FF, s9);
    p0 = -1;
    for (int p = 254; p >= 0; p--)
      if (expect_at(p) === s0 && expect_at(p + 1) === s1)
        p0 = p;
    check(16'(p0 >= 0), 16'h0001, "first samples");
    check(s9, expect_at(p0 + 511), "last sample");
    $display("test default capture done");
  endtask

  task automatic t_stop();
    wr(ela_pkg::ELA_OP_WR_VAL, 6'h00, 16'h00FF);
    wr(ela_pkg::ELA_OP_WR_MASK, 6'h00, 16'h00FF);
    wr(ela_pkg::ELA_OP_ARM, 6'h00, 16'h0000);
    repeat (300) @(posedge core_clk);
    wait_state(2'h1, 1);
    wr(ela_pkg::ELA_OP_STOP, 6'h00, 16'h0000);
    wait_state(2'h0, 3);
    $display("test stop done");
  endtask

  task automatic t_compare();
    ela_case_t   cs [11];
    logic [15:0] r;
    cs = '{'{4'h0, 8'h25, 8'h00, 8'hFF, 4'h0, 8'h00, 1'b0, 8'h25},
           '{4'h1, 8'h00, 8'h00, 8'hFE, 4'h4, 8'h02, 1'b1, 8'h02},
           '{4'h2, 8'hFD, 8'h00, 8'hFF, 4'h0, 8'h00, 1'b0, 8'hFE},
           '{4'h3, 8'h01, 8'h00, 8'hFF, 4'h0, 8'h00, 1'b0, 8'h00},
           '{4'h4, 8'h00, 8'h00, 8'hFF, 4'h0, 8'h00, 1'b0, 8'h00},
           '{4'h5, 8'hFE, 8'h00, 8'hFF, 4'h0, 8'h00, 1'b0, 8'hFE},
           '{4'h6, 8'h64, 8'h6E, 8'hFF, 4'h4, 8'h64, 1'b1, 8'h64},
           '{4'h7, 8'h01, 8'hFD, 8'hFF, 4'h5, 8'h01, 1'b1, 8'hFE},
           '{4'h8, 8'h00, 8'h00, 8'h80, 4'h0, 8'h00, 1'b0, 8'h80},
           '{4'h9, 8'h00, 8'h00, 8'h80, 4'h0, 8'h00, 1'b0, 8'h00},
           '{4'h5, 8'hC8, 8'h00, 8'hFF, 4'h4, 8'hC8, 1'b1, 8'hC8}};
    wr(ela_pkg::ELA_OP_WR_MASK, 6'h01, 16'h00FF);
    foreach (cs[i]) begin
      wr(ela_pkg::ELA_OP_WR_VAL, 6'h00, {8'h00, cs[i].val});
      wr(ela_pkg::ELA_OP_WR_HI, 6'h00, {8'h00, cs[i].hi});
      wr(ela_pkg::ELA_OP_WR_MASK, 6'h00, {8'h00, cs[i].msk});
      wr(ela_pkg::ELA_OP_WR_CMP, 6'h00, {11'h000, 1'b1, cs[i].cmp});
      wr(ela_pkg::ELA_OP_WR_VAL, 6'h01, {8'h00, cs[i].val1});
      wr(ela_pkg::ELA_OP_WR_CMP, 6'h01, {11'h000, cs[i].en1, cs[i].cmp1});
      wr(ela_pkg::ELA_OP_ARM, 6'h00, 16'h0000);
      wait_state(2'h3, 20);
      run(ela_pkg::ELA_OP_RD_DATA, 6'h00, 16'h0000, r);
      check(r, expect_at(cs[i].hit), "trigger sample");
    end
    $display("test compare modes done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    n_mismatch = 0;
    check_count = 0;
    resetn = 1'b0;
    fork
      repeat (12) @(posedge core_clk);
      host_u.idle(2);
    join
    #1;
    check({14'h0000, led, tdo}, 16'h0000, "outputs in reset");
    resetn = 1'b1;
    host_u.idle(3);
    t_led();
    t_default();
    t_stop();
    t_compare();
    report_and_stop();
  end

  // The full sequence needs roughly 500 us; the limit leaves a margin.
  initial begin
    #1000000;
    n_mismatch++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
